//--- aisc_core.sv
// aisc package with shared constants, and the per-sample correction datapath
`timescale 1ns/1ps
package aisc_pkg;
  // -----------------------------------------------------------------------
  // sizes
  // -----------------------------------------------------------------------
  localparam int NUM_CH   = 8;
  localparam int CH_W     = 3;
  localparam int GRP_W    = 3;
  localparam int NUM_GRP  = 8;
  localparam int DATA_W   = 16;
  // -----------------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------------
  localparam longint unsigned CLK_HZ        = 40_000_000;
  localparam longint unsigned REF_PERIOD_S  = 60;
  localparam longint unsigned REF_PERIOD_CYC = REF_PERIOD_S * CLK_HZ;
  // -----------------------------------------------------------------------
  // reference check and calibration
  // -----------------------------------------------------------------------
  localparam logic [15:0] REF_NOMINAL = 16'h8000;
  localparam logic [15:0] REF_LIM_LO  = 16'h7000;
  localparam logic [15:0] REF_LIM_HI  = 16'h9000;
  localparam logic [15:0] SCALE_RST   = 16'h8000;
  localparam logic [15:0] OFFSET_RST  = 16'h0000;
  localparam int          SCALE_FRAC  = 15;
  // -----------------------------------------------------------------------
  // sequencer states
  // -----------------------------------------------------------------------
  typedef enum logic [3:0] {
    AISC_IDLE  = 4'b0001,
    AISC_START = 4'b0010,
    AISC_WAIT  = 4'b0100,
    AISC_STORE = 4'b1000
  } aisc_state_t;
endpackage

// -------------------------------------------------------------------------
// corrected = raw * scale (q1.15) + offset, clamped to the converter range
// -------------------------------------------------------------------------
module aisc_corr (
  input  wire logic [15:0] raw,
  input  wire logic [15:0] scale,
  input  wire logic [15:0] offset,
  output logic      [15:0] corrected
);
  logic [31:0]        prod;
  logic signed [18:0] sum;

  assign prod = raw * scale;
  // multiply first, then add the offset
  assign sum  = $signed({2'b00, prod[31:15]}) + $signed({{3{offset[15]}}, offset});
  // clamp keeps a bad constant from wrapping a reading around
  assign corrected = sum[18] ? 16'h0000 : (|sum[17:16] ? 16'hFFFF : sum[15:0]);
endmodule

//--- aisc_scan.sv
// eight-channel input scan sequencer with reference check and fault indicator
//
// Summary of operation
// [R01] each channel's input mux selects its reference or field input
// [R02] channel mux picks one of eight channels for the 16-bit converter
// [R03] corrected result written to dual-port memory for host reads
// [R04] each channel has its own reference, routed independently
// [R05] references read once per minute, only while no field reads pending
// [R06] reference reading outside limits sets that channel's fault flag
// [R07] scale and offset from reference; sample times scale plus offset
// [R08] host assigns each channel's rate group during initialization
// [R09] host broadcasts key; only channels in named groups are updated
// [R10] device schedules rate groups itself from assignments and keys
// [R11] host lights indicator after reset, clears it when diagnostics pass
// [R12] indicator off only after self-test passes and host init completes
// [R13] red indicator lit on any channel fault or board fault
// [R14] channel fault clears when a later reference check is within limits
`timescale 1ns/1ps
module aisc_scan #(
  parameter longint unsigned REF_PERIOD_CYC = aisc_pkg::REF_PERIOD_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cfg_we,
  input  wire logic [2:0]  cfg_ch,
  input  wire logic [2:0]  cfg_group,
  input  wire logic        cfg_done,
  input  wire logic        key_valid,
  input  wire logic [7:0]  key_groups,
  input  wire logic        self_test_ok,
  input  wire logic        host_led_on,
  input  wire logic        adc_done,
  input  wire logic [15:0] adc_data,
  output logic             adc_start,
  output logic [2:0]       ch_sel,
  output logic [7:0]       ref_sel,
  output logic             dp_we,
  output logic [2:0]       dp_addr,
  output logic [15:0]      dp_data,
  output logic [7:0]       fault,
  output logic             led_red
);
  // -----------------------------------------------------------------------
  // state
  // -----------------------------------------------------------------------
  aisc_pkg::aisc_state_t state_r, state_nxt;
  logic [2:0]  grp_r [8];
  logic [15:0] scale_r [8];
  logic [15:0] offset_r [8];
  logic [7:0]  pend_r, ref_pend_r, fault_r, ref_sel_r;
  logic [2:0]  ch_sel_r, dp_addr_r;
  logic        is_ref_r, adc_start_r, dp_we_r, led_r, init_done_r;
  logic [15:0] sample_r, dp_data_r;
  logic [31:0] tick_cnt_r;
  logic        sync1_r, sync2_r, sync3_r, done_lvl_r;

  // -----------------------------------------------------------------------
  // decode
  // -----------------------------------------------------------------------
  function automatic logic [2:0] first_one(input logic [7:0] m);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  localparam logic [31:0] TICK_LAST = 32'(REF_PERIOD_CYC - 1);

  logic        tick;
  logic        done_rise;
  logic [7:0]  key_hit;
  logic [7:0]  pend_clr, ref_clr;
  logic        pick_field, pick_ref;
  logic [2:0]  pick_ch;
  logic        ref_ok;
  logic [15:0] corr_out;
  logic [15:0] corr_scale, corr_off;
  logic [15:0] new_scale;
  logic [31:0] ref_prod;
  logic signed [17:0] off_wide;
  logic [15:0] new_off;
  logic        store_fire;

  assign tick       = (tick_cnt_r == TICK_LAST);
  // a done rise counts once the second and third stages agree
  assign done_rise  = (sync2_r == sync3_r) && sync3_r && !done_lvl_r;
  assign pick_field = |pend_r;
  // [R05] references only when idle
  assign pick_ref   = !pick_field && |ref_pend_r;
  assign pick_ch    = pick_field ? first_one(pend_r) : first_one(ref_pend_r);
  assign store_fire = (state_r == aisc_pkg::AISC_STORE);
  assign pend_clr   = (store_fire && !is_ref_r) ? 8'(1 << ch_sel_r) : 8'h00;
  assign ref_clr    = (store_fire && is_ref_r) ? 8'(1 << ch_sel_r) : 8'h00;
  assign ref_ok     = (sample_r >= aisc_pkg::REF_LIM_LO) && (sample_r <= aisc_pkg::REF_LIM_HI);
  // [R07] first-order gain trim: nominal is half scale, so nom/ref ~ 2 - ref
  assign new_scale  = 16'(17'h10000 - {1'b0, sample_r});
  assign ref_prod   = sample_r * new_scale;
  assign off_wide   = $signed({2'b00, aisc_pkg::REF_NOMINAL})
                    - $signed({1'b0, ref_prod[31:15]});
  assign new_off    = off_wide[15:0];
  assign corr_scale = scale_r[ch_sel_r];
  assign corr_off   = offset_r[ch_sel_r];

  generate
    for (genvar g = 0; g < 8; g++) begin : g_hit
      // [R09] channel due when its group is keyed
      assign key_hit[g] = key_valid && init_done_r && key_groups[grp_r[g]];
    end
  endgenerate

  // [R07] sample times scale plus offset
  aisc_corr u_corr (
    .raw       (sample_r),
    .scale     (corr_scale),
    .offset    (corr_off),
    .corrected (corr_out)
  );

  // -----------------------------------------------------------------------
  // sequencer
  // -----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      aisc_pkg::AISC_IDLE: begin
        if (init_done_r && (pick_field || pick_ref)) begin
          state_nxt = aisc_pkg::AISC_START;
        end
      end
      aisc_pkg::AISC_START: begin
        state_nxt = aisc_pkg::AISC_WAIT;
      end
      aisc_pkg::AISC_WAIT: begin
        if (done_rise) begin
          state_nxt = aisc_pkg::AISC_STORE;
        end
      end
      aisc_pkg::AISC_STORE: begin
        state_nxt = aisc_pkg::AISC_IDLE;
      end
      default: begin
        state_nxt = aisc_pkg::AISC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= aisc_pkg::AISC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // -----------------------------------------------------------------------
  // converter handshake and mux steering
  // -----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r    <= 1'b0;
      sync2_r    <= 1'b0;
      sync3_r    <= 1'b0;
      done_lvl_r <= 1'b0;
    end else begin
      sync1_r <= adc_done;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r) begin
        done_lvl_r <= sync3_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ch_sel_r    <= 3'h0;
      ref_sel_r   <= 8'h00;
      is_ref_r    <= 1'b0;
      adc_start_r <= 1'b0;
      sample_r    <= 16'h0000;
    end else begin
      adc_start_r <= (state_r == aisc_pkg::AISC_START);
      if (state_r == aisc_pkg::AISC_IDLE && state_nxt == aisc_pkg::AISC_START) begin
        // [R02] one channel to the converter
        ch_sel_r  <= pick_ch;
        is_ref_r  <= pick_ref;
        // [R01] [R04] per-channel reference route
        ref_sel_r <= pick_ref ? 8'(1 << pick_ch) : 8'h00;
      end else if (store_fire) begin
        ref_sel_r <= 8'h00;
      end
      if (state_r == aisc_pkg::AISC_WAIT && done_rise) begin
        sample_r <= adc_data;
      end
    end
  end

  // -----------------------------------------------------------------------
  // configuration and scheduling
  // -----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        grp_r[i] <= 3'h0;
      end
      init_done_r <= 1'b0;
    end else begin
      // [R08] host-written group per channel
      if (cfg_we) begin
        grp_r[cfg_ch] <= cfg_group;
      end
      if (cfg_done) begin
        init_done_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pend_r     <= 8'h00;
      ref_pend_r <= 8'h00;
      tick_cnt_r <= 32'h0000_0000;
    end else begin
      // [R10] local scheduling; a new key wins over a clear
      pend_r     <= (pend_r & ~pend_clr) | key_hit;
      tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
      // [R05] once-per-minute sweep
      ref_pend_r <= (ref_pend_r & ~ref_clr) | ((tick && init_done_r) ? 8'hFF : 8'h00);
    end
  end

  // -----------------------------------------------------------------------
  // result store, calibration, faults
  // -----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      dp_we_r   <= 1'b0;
      dp_addr_r <= 3'h0;
      dp_data_r <= 16'h0000;
    end else begin
      // [R03] corrected value to dual-port memory
      dp_we_r <= store_fire && !is_ref_r;
      if (store_fire && !is_ref_r) begin
        dp_addr_r <= ch_sel_r;
        dp_data_r <= corr_out;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        scale_r[i]  <= aisc_pkg::SCALE_RST;
        offset_r[i] <= aisc_pkg::OFFSET_RST;
      end
      fault_r <= 8'h00;
    end else if (store_fire && is_ref_r) begin
      // [R06] [R14] flag follows the latest reference check
      fault_r[ch_sel_r] <= !ref_ok;
      // [R07] constants only from a trusted reading
      if (ref_ok) begin
        scale_r[ch_sel_r]  <= new_scale;
        offset_r[ch_sel_r] <= new_off;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      led_r <= 1'b1;
    end else begin
      // [R12] [R13] board fault until self-test and host init; [R11] host hold
      led_r <= |fault_r || !(self_test_ok && init_done_r) || host_led_on;
    end
  end

  assign adc_start = adc_start_r;
  assign ch_sel    = ch_sel_r;
  assign ref_sel   = ref_sel_r;
  assign dp_we     = dp_we_r;
  assign dp_addr   = dp_addr_r;
  assign dp_data   = dp_data_r;
  assign fault     = fault_r;
  assign led_red   = led_r;
endmodule

//--- aisc_scan_asserts.sv
// port assertions for the scan sequencer
`timescale 1ns/1ps
module aisc_scan_chk #(
  parameter longint unsigned REF_PERIOD_CYC = 200
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       self_test_ok,
  input wire logic       host_led_on,
  input wire logic       adc_start,
  input wire logic [2:0] ch_sel,
  input wire logic [7:0] ref_sel,
  input wire logic       dp_we,
  input wire logic [2:0] dp_addr,
  input wire logic [7:0] fault,
  input wire logic       led_red
);
  // -----------------------------------------------------------------------
  // properties
  // -----------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_start_pulse: assert property (adc_start |=> !adc_start)
    else $error("start pulse longer than one cycle");
  a_write_pulse: assert property (dp_we |=> !dp_we)
    else $error("write pulse longer than one cycle");
  a_ref_onehot: assert property (ref_sel != 8'h00 |-> ref_sel == (8'h01 << ch_sel))
    else $error("reference select not on the picked channel");
  a_ref_no_write: assert property (ref_sel != 8'h00 |-> !dp_we)
    else $error("reference reading written to memory");
  a_write_addr: assert property (dp_we |-> dp_addr == ch_sel)
    else $error("write address differs from channel select");
  a_start_write: assert property (adc_start && ref_sel == 8'h00 |-> ##[5:30] dp_we)
    else $error("field conversion not stored in time");
  a_led_fault: assert property (fault != 8'h00 |=> led_red)
    else $error("indicator dark with a channel fault");
  a_led_board: assert property (!self_test_ok || host_led_on |=> led_red)
    else $error("indicator dark with a board fault");
  a_reset_vals: assert property (disable iff (1'b0) rst |=> fault == 8'h00 && led_red && !dp_we)
    else $error("outputs not at reset values");
endmodule
bind aisc_scan aisc_scan_chk #(.REF_PERIOD_CYC(REF_PERIOD_CYC)) chk_u (
  .clk(clk), .rst(rst), .self_test_ok(self_test_ok), .host_led_on(host_led_on),
  .adc_start(adc_start), .ch_sel(ch_sel), .ref_sel(ref_sel), .dp_we(dp_we),
  .dp_addr(dp_addr), .fault(fault), .led_red(led_red));

//--- aisc_adc_model.sv
// converter model answering start pulses
`timescale 1ns/1ps
module aisc_adc_model (
  input  wire logic       clk,
  input  wire logic       adc_start,
  input  wire logic [2:0] ch_sel,
  input  wire logic [7:0] ref_sel,
  input  wire logic [3:0] dly,
  output logic            adc_done,
  output logic [15:0]     adc_data
);
  // -----------------------------------------------------------------------
  // conversion timing
  // -----------------------------------------------------------------------
  logic [15:0] ref_v [8];
  logic [15:0] val = 16'h0000;
  int          cnt = 0;
  initial begin
    for (int i = 0; i < 8; i++) ref_v[i] = 16'h8000;
    ref_v[3] = 16'hA000;
  end
  always @(posedge clk) begin
    if (adc_start) begin
      val <= (ref_sel != 8'h00) ? ref_v[ch_sel] : 16'h1000 + 16'(ch_sel);
      cnt <= 1;
    end else if (cnt != 0) begin
      cnt <= (cnt == dly + 5) ? 0 : cnt + 1;
    end
  end
  // done drops well before the next start, data inverted once released
  assign adc_done = cnt != 0 && cnt >= dly && cnt < dly + 5;
  assign adc_data = adc_done ? val : ~val;
endmodule

//--- analog_input_scan_control_test.sv
// self-checking bench for the scan sequencer
`timescale 1ns/1ps
module analog_input_scan_control_test;
  // -----------------------------------------------------------------------
  // stimulus, counters, instances
  // -----------------------------------------------------------------------
  logic        clk = 1'b0, rst = 1'b1, cfg_we = 1'b0, cfg_done = 1'b0;
  logic        key_valid = 1'b0, self_test_ok = 1'b0, host_led_on = 1'b0;
  logic [2:0]  cfg_ch = 3'h0, cfg_group = 3'h0;
  logic [7:0]  key_groups = 8'h00;
  logic [3:0]  dly = 4'h3;
  logic        adc_start, adc_done, dp_we, led_red;
  logic [2:0]  ch_sel, dp_addr;
  logic [7:0]  ref_sel, fault;
  logic [15:0] adc_data, dp_data;
  int          fail_count = 0, checks = 0, cyc = 0, starts = 0, writes = 0;
  initial begin
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    starts <= starts + 32'(adc_start);
    writes <= writes + 32'(dp_we);
    if (cyc == 4000) begin
      fail_count++;
      give_verdict();
    end
  end
  aisc_scan #(.REF_PERIOD_CYC(200)) dut_u (.clk(clk), .rst(rst), .cfg_we(cfg_we),
    .cfg_ch(cfg_ch), .cfg_group(cfg_group), .cfg_done(cfg_done), .key_valid(key_valid),
    .key_groups(key_groups), .self_test_ok(self_test_ok), .host_led_on(host_led_on),
    .adc_done(adc_done), .adc_data(adc_data), .adc_start(adc_start), .ch_sel(ch_sel),
    .ref_sel(ref_sel), .dp_we(dp_we), .dp_addr(dp_addr), .dp_data(dp_data),
    .fault(fault), .led_red(led_red));
  aisc_adc_model adc_u (.clk(clk), .adc_start(adc_start), .ch_sel(ch_sel),
    .ref_sel(ref_sel), .dly(dly), .adc_done(adc_done), .adc_data(adc_data));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic key(input logic [7:0] g);
    @(posedge clk);
    key_valid <= 1'b1;
    key_groups <= g;
    @(posedge clk);
    key_valid <= 1'b0;
  endtask
  task automatic wait_we(input logic [2:0] a, input logic [15:0] d);
    int n;
    n = 0;
    while (dp_we !== 1'b1 && n < 80) begin
      tick(1);
      n++;
    end
    chk({15'h0000, dp_we}, 16'h0001);
    chk({13'h0000, dp_addr}, {13'h0000, a});
    chk({13'h0000, ch_sel}, {13'h0000, a});
    chk(dp_data, d);
    tick(1);
  endtask
  // a full reference pass, channel 0 through 7
  task automatic wait_round();
    while (ref_sel !== 8'h00) tick(1);
    while (ref_sel[0] !== 1'b1) tick(1);
    chk({8'h00, ref_sel}, 16'h0001);
    while (ref_sel[7] !== 1'b1) tick(1);
    while (ref_sel !== 8'h00) tick(1);
    tick(2);
  endtask
  // -----------------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------------
  task automatic t_early();
    chk({15'h0000, led_red}, 16'h0001);
    key(8'hFF);
    tick(20);
    chk(16'(starts), 16'h0000);
  endtask
  task automatic t_cfg();
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      cfg_we <= 1'b1;
      cfg_ch <= 3'(i);
      cfg_group <= 3'(i);
    end
    @(posedge clk);
    cfg_we <= 1'b0;
    cfg_done <= 1'b1;
    @(posedge clk);
    cfg_done <= 1'b0;
    tick(3);
    chk({15'h0000, led_red}, 16'h0001);
    @(posedge clk);
    self_test_ok <= 1'b1;
    tick(3);
    chk({15'h0000, led_red}, 16'h0000);
    @(posedge clk);
    host_led_on <= 1'b1;
    tick(3);
    chk({15'h0000, led_red}, 16'h0001);
    @(posedge clk);
    host_led_on <= 1'b0;
  endtask
  // slow converter, two groups keyed at once
  task automatic t_key();
    int w0;
    w0 = writes;
    dly <= 4'h9;
    key(8'h24);
    wait_we(3'h2, 16'h1002);
    wait_we(3'h5, 16'h1005);
    tick(30);
    chk(16'(writes - w0), 16'h0002);
  endtask
  task automatic t_ref();
    int w0, s0;
    dly <= 4'h3;
    w0 = writes;
    while (ref_sel[0] !== 1'b1) tick(1);
    chk({8'h00, ref_sel}, 16'h0001);
    // a key in mid-sweep must go ahead of the remaining references
    key(8'h01);
    tick(1);
    s0 = starts;
    wait_we(3'h0, 16'h1000);
    chk(16'(starts - s0), 16'h0001);
    while (ref_sel[7] !== 1'b1) tick(1);
    chk({8'h00, ref_sel}, 16'h0080);
    while (ref_sel !== 8'h00) tick(1);
    tick(2);
    chk(16'(writes - w0), 16'h0001);
    chk({8'h00, fault}, 16'h0008);
    chk({15'h0000, led_red}, 16'h0001);
    adc_u.ref_v[3] = 16'h7800;
    wait_round();
    chk({8'h00, fault}, 16'h0000);
    chk({15'h0000, led_red}, 16'h0000);
    key(8'h08);
    wait_we(3'h3, 16'h1183);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    t_early();
    t_cfg();
    t_key();
    t_ref();
    give_verdict();
  end
endmodule
